//--- src/fe_pcs_pkg.sv
/*
 Package for the 100BASE-X coding block: code groups, timing counts.
 Assumes a 200 MHz system clock.
*/
package fe_pcs_pkg;
    localparam int unsigned CLK_MHZ = 200;
    localparam logic [4:0] CG_IDLE = 5'h1F;
    localparam logic [4:0] CG_J = 5'h18;
    localparam logic [4:0] CG_K = 5'h11;
    localparam logic [4:0] CG_T = 5'h0D;
    localparam logic [4:0] CG_R = 5'h07;
    localparam logic [4:0] CG_H = 5'h04;
    localparam logic [3:0] NIB_PREAMBLE = 4'h5;
    localparam logic [3:0] NIB_ERROR = 4'h5;
    // Link qualification times
    localparam int unsigned LOCK_TIME_MS = 50;
    localparam int unsigned IDLE_WINDOW_MS = 2;
    localparam int unsigned LOCK_CYCLES = LOCK_TIME_MS * 1000 * CLK_MHZ;
    localparam int unsigned IDLE_WINDOW_CYCLES = IDLE_WINDOW_MS * 1000 * CLK_MHZ;
    localparam int unsigned IDLE_RUN_MIN = 16;
    // 25 MHz MII clock: toggle every 4 system cycles
    localparam int unsigned MII_HALF_PERIOD = 4;
    localparam int unsigned LINK10_HOLD_CYCLES = 1000;
endpackage : fe_pcs_pkg

//--- src/fe_sym_codec.sv
/*
 4B/5B code group encode and decode functions wrapped as a small module.
 Purely combinational; assumes the caller registers its outputs.
*/
`timescale 1ns/1ps
`default_nettype none
module fe_sym_codec (
    input wire logic [3:0] enc_nib_i, // Nibble to encode
    output logic [4:0] enc_cg_o, // Data code group
    input wire logic [4:0] dec_cg_i, // Code group to decode
    output logic [3:0] dec_nib_o, // Decoded nibble
    output logic dec_ok_o // Code group is a data group
);
    // ----------------------------------------
    // Encoder table
    // ----------------------------------------
    always_comb begin
        unique case (enc_nib_i)
            4'h0: enc_cg_o = 5'h1E;
            4'h1: enc_cg_o = 5'h09;
            4'h2: enc_cg_o = 5'h14;
            4'h3: enc_cg_o = 5'h15;
            4'h4: enc_cg_o = 5'h0A;
            4'h5: enc_cg_o = 5'h0B;
            4'h6: enc_cg_o = 5'h0E;
            4'h7: enc_cg_o = 5'h0F;
            4'h8: enc_cg_o = 5'h12;
            4'h9: enc_cg_o = 5'h13;
            4'hA: enc_cg_o = 5'h16;
            4'hB: enc_cg_o = 5'h17;
            4'hC: enc_cg_o = 5'h1A;
            4'hD: enc_cg_o = 5'h1B;
            4'hE: enc_cg_o = 5'h1C;
            4'hF: enc_cg_o = 5'h1D;
        endcase
    end

    // ----------------------------------------
    // Decoder; control and invalid groups flag not-ok
    // ----------------------------------------
    always_comb begin
        dec_ok_o = 1'b1;
        dec_nib_o = 4'h0;
        unique case (dec_cg_i)
            5'h1E: dec_nib_o = 4'h0;
            5'h09: dec_nib_o = 4'h1;
            5'h14: dec_nib_o = 4'h2;
            5'h15: dec_nib_o = 4'h3;
            5'h0A: dec_nib_o = 4'h4;
            5'h0B: dec_nib_o = 4'h5;
            5'h0E: dec_nib_o = 4'h6;
            5'h0F: dec_nib_o = 4'h7;
            5'h12: dec_nib_o = 4'h8;
            5'h13: dec_nib_o = 4'h9;
            5'h16: dec_nib_o = 4'hA;
            5'h17: dec_nib_o = 4'hB;
            5'h1A: dec_nib_o = 4'hC;
            5'h1B: dec_nib_o = 4'hD;
            5'h1C: dec_nib_o = 4'hE;
            5'h1D: dec_nib_o = 4'hF;
            default: dec_ok_o = 1'b0;
        endcase
    end
endmodule // fe_sym_codec
`default_nettype wire

//--- src/fe_pcs_pma.sv
/*
 100BASE-X coding and link logic: MII transmit to code groups, code groups
 back to MII receive, link qualification, carrier sense, link-failure override.
 Assumes one 200 MHz clock; the MII clocks are made here by a divider and the
 code-group streams are exchanged one group per MII clock tick.
*/
`timescale 1ns/1ps
`default_nettype none
module fe_pcs_pma (
    input wire logic clk_i, // 200 MHz system clock
    input wire logic rst_i, // Synchronous reset, active high
    output logic mii_clk_o, // 25 MHz transmit and receive clock
    input wire logic tx_en_i, // Transmit enable from MAC
    input wire logic tx_er_i, // Transmit error from MAC
    input wire logic [3:0] txd_i, // Transmit nibble
    output logic [4:0] tx_cg_o, // Code group to line driver
    output logic tx_flp_o, // Link pulse bursts requested instead of data
    input wire logic [4:0] rx_cg_i, // Code group from descrambler
    input wire logic lock_i, // Descrambler locked (asynchronous)
    input wire logic link10_hint_i, // 10 Mbps receiver link indication
    output logic [3:0] rxd_o, // Receive nibble
    output logic rx_dv_o, // Receive data valid
    output logic rx_er_o, // Receive error
    output logic crs_o, // Carrier sense
    input wire logic an_enable_i, // Auto-negotiation enabled
    input wire logic link_override_i, // Link-failure override (16.14)
    output logic link_up_o, // Link status (1.2 / 17.10)
    output logic link_lost_o, // One-cycle link loss event
    output logic an_restart_o, // One-cycle negotiation restart
    output logic link10_o // Permanent 10 Mbps link, never from TX idle
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef enum logic [2:0] {TX_IDLE, TX_K, TX_DATA, TX_T, TX_R} tx_state_type;
    typedef enum logic [1:0] {RX_IDLE, RX_GOT_J, RX_FRAME, RX_GOT_T} rx_state_type;

    typedef struct packed {
        logic [1:0] div;
        logic mii_clk;
        tx_state_type tx_st;
        logic [4:0] tx_cg;
        rx_state_type rx_st;
        logic [4:0] rx_prev;
        logic [3:0] rxd;
        logic rx_dv;
        logic rx_er;
        logic crs;
        logic [1:0] lock_sync;
        logic [31:0] lock_cnt;
        logic [31:0] win_cnt;
        logic [4:0] idle_run;
        logic run_seen;
        logic link_up;
        logic link_lost;
        logic an_restart;
    } state_type;

    state_type q, d;
    logic tick;
    logic [4:0] enc_cg;
    logic [3:0] dec_nib;
    logic dec_ok;
    logic tx_allowed;

    fe_sym_codec u_codec (
        .enc_nib_i(txd_i),
        .enc_cg_o(enc_cg),
        .dec_cg_i(q.rx_prev),
        .dec_nib_o(dec_nib),
        .dec_ok_o(dec_ok)
    );

    // Symbol tick on the MII clock rising edge
    assign tick = (q.div == 2'(fe_pcs_pkg::MII_HALF_PERIOD - 1)) && !q.mii_clk;
    // Data only with link, or with override and negotiation off
    assign tx_allowed = q.link_up || (link_override_i && !an_enable_i);

    // ----------------------------------------
    // Next-state logic
    // ----------------------------------------
    always_comb begin
        d = q;
        d.link_lost = 1'b0;
        d.an_restart = 1'b0;
        d.lock_sync = {q.lock_sync[0], lock_i};
        // Clock divider, 200/8 = 25 MHz
        if (q.div == 2'(fe_pcs_pkg::MII_HALF_PERIOD - 1)) begin
            d.div = 2'h0;
            d.mii_clk = !q.mii_clk;
        end else begin
            d.div = q.div + 2'h1;
        end
        // Transmit path, one code group per tick
        if (tick) begin
            unique case (q.tx_st)
                TX_IDLE: begin
                    if (tx_en_i && tx_allowed) begin
                        d.tx_cg = fe_pcs_pkg::CG_J;
                        d.tx_st = TX_K;
                    end else begin
                        d.tx_cg = fe_pcs_pkg::CG_IDLE;
                    end
                end
                TX_K: begin
                    d.tx_cg = fe_pcs_pkg::CG_K;
                    d.tx_st = TX_DATA;
                end
                TX_DATA: begin
                    if (!tx_en_i) begin
                        d.tx_cg = fe_pcs_pkg::CG_T;
                        d.tx_st = TX_R;
                    end else if (tx_er_i) begin
                        d.tx_cg = fe_pcs_pkg::CG_H;
                    end else begin
                        d.tx_cg = enc_cg;
                    end
                end
                TX_T: begin
                    d.tx_cg = fe_pcs_pkg::CG_T;
                    d.tx_st = TX_R;
                end
                TX_R: begin
                    d.tx_cg = fe_pcs_pkg::CG_R;
                    d.tx_st = TX_IDLE;
                end
                default: begin
                    d.tx_cg = fe_pcs_pkg::CG_IDLE;
                    d.tx_st = TX_IDLE;
                end
            endcase
        end
        // Receive path; decodes the previous group and peeks at the current one,
        // which costs one tick of latency but lets J/K become two preamble nibbles
        if (tick) begin
            d.rx_er = 1'b0;
            d.rx_prev = rx_cg_i;
            unique case (q.rx_st)
                RX_IDLE: begin
                    d.rx_dv = 1'b0;
                    d.rxd = 4'h0;
                    if (q.rx_prev == fe_pcs_pkg::CG_J && rx_cg_i == fe_pcs_pkg::CG_K) begin
                        d.crs = 1'b1;
                        d.rx_dv = 1'b1;
                        d.rxd = fe_pcs_pkg::NIB_PREAMBLE;
                        d.rx_st = RX_GOT_J;
                    end
                end
                RX_GOT_J: begin
                    // Second preamble nibble stands in for K
                    d.rx_dv = 1'b1;
                    d.rxd = fe_pcs_pkg::NIB_PREAMBLE;
                    d.rx_st = RX_FRAME;
                end
                RX_FRAME: begin
                    if (q.rx_prev == fe_pcs_pkg::CG_T) begin
                        d.rx_dv = 1'b0;
                        d.rx_st = RX_GOT_T;
                    end else if (q.rx_prev == fe_pcs_pkg::CG_IDLE) begin
                        d.crs = 1'b0;
                        d.rx_er = 1'b1;
                        d.rx_dv = 1'b0;
                        d.rx_st = RX_IDLE;
                    end else if (dec_ok) begin
                        d.rx_dv = 1'b1;
                        d.rxd = dec_nib;
                    end else begin
                        d.rx_er = 1'b1;
                        d.rxd = fe_pcs_pkg::NIB_ERROR;
                    end
                end
                RX_GOT_T: begin
                    d.crs = 1'b0;
                    d.rx_st = RX_IDLE;
                    if (q.rx_prev != fe_pcs_pkg::CG_R) begin
                        d.rx_er = 1'b1;
                    end
                end
                default: d.rx_st = RX_IDLE;
            endcase
        end
        // Link qualification
        if (!q.lock_sync[1]) begin
            d.lock_cnt = 32'h0;
        end else if (q.lock_cnt < 32'(fe_pcs_pkg::LOCK_CYCLES)) begin
            d.lock_cnt = q.lock_cnt + 32'h1;
        end
        if (tick) begin
            if (rx_cg_i == fe_pcs_pkg::CG_IDLE) begin
                if (q.idle_run < 5'(fe_pcs_pkg::IDLE_RUN_MIN)) begin
                    d.idle_run = q.idle_run + 5'h1;
                end
            end else begin
                d.idle_run = 5'h0;
            end
        end
        if (q.idle_run >= 5'(fe_pcs_pkg::IDLE_RUN_MIN)) begin
            d.run_seen = 1'b1;
        end
        if (!q.link_up) begin
            d.win_cnt = 32'h0;
            d.run_seen = 1'b0;
            if (q.lock_cnt >= 32'(fe_pcs_pkg::LOCK_CYCLES)) begin
                d.link_up = 1'b1;
            end
        end else if (q.win_cnt == 32'(fe_pcs_pkg::IDLE_WINDOW_CYCLES - 1)) begin
            d.win_cnt = 32'h0;
            d.run_seen = 1'b0;
            if (!q.run_seen) begin
                d.link_up = 1'b0;
                d.lock_cnt = 32'h0;
                d.link_lost = 1'b1;
                d.an_restart = an_enable_i;
            end
        end else begin
            d.win_cnt = q.win_cnt + 32'h1;
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
            q.tx_st <= TX_IDLE;
            q.rx_st <= RX_IDLE;
            q.tx_cg <= fe_pcs_pkg::CG_IDLE;
        end else begin
            q <= d;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign mii_clk_o = q.mii_clk;
    assign tx_cg_o = q.tx_cg;
    // Without link, negotiation sends pulse bursts
    assign tx_flp_o = an_enable_i && !q.link_up;
    assign rxd_o = q.rxd;
    assign rx_dv_o = q.rx_dv;
    assign rx_er_o = q.rx_er;
    assign crs_o = q.crs;
    assign link_up_o = q.link_up;
    assign link_lost_o = q.link_lost;
    assign an_restart_o = q.an_restart;
    // 10 Mbps link never latched from idle waveforms here
    assign link10_o = 1'b0;
endmodule // fe_pcs_pma
`default_nettype wire

//--- dv/fe_pcs_chk.sv
/*
 Checker for the coding block: group order, receive flags, link events.
 Assumes it is bound into fe_pcs_pma and that a tick lasts 8 clocks.
*/
`timescale 1ns/1ps
`default_nettype none
module fe_pcs_chk (
    input wire logic clk_i, // Clock
    input wire logic rst_i, // Reset
    input wire logic mii_clk_o, // MII clock
    input wire logic tx_en_i, // Transmit enable
    input wire logic [4:0] tx_cg_o, // Line group
    input wire logic tx_flp_o, // Pulse request
    input wire logic [3:0] rxd_o, // Receive nibble
    input wire logic rx_dv_o, // Receive valid
    input wire logic rx_er_o, // Receive error
    input wire logic crs_o, // Carrier
    input wire logic an_enable_i, // Negotiation on
    input wire logic link_override_i, // Override
    input wire logic link_up_o, // Link
    input wire logic link_lost_o, // Loss event
    input wire logic an_restart_o, // Restart event
    input wire logic link10_o // Slow link
);
    // ------
    // Properties
    // ------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Transmit gating; a tick's new group shows in the same clock that mii_clk rises
    tx_gate_a: assert property (
        !link_up_o && (!link_override_i || an_enable_i) |-> tx_cg_o == fe_pcs_pkg::CG_IDLE)
        else $error("data sent without link");
    pulse_req_a: assert property (
        tx_flp_o == (an_enable_i && !link_up_o)) else $error("pulse request wrong");
    ssd_start_a: assert property (
        $rose(mii_clk_o) && $past(tx_en_i) && !$past(tx_en_i, 9) && $past(tx_cg_o) == fe_pcs_pkg::CG_IDLE
        && link_override_i && !an_enable_i |-> tx_cg_o == fe_pcs_pkg::CG_J) else $error("no J at start");
    ssd_pair_a: assert property (
        $rose(mii_clk_o) && tx_cg_o == fe_pcs_pkg::CG_J |-> ##8 tx_cg_o == fe_pcs_pkg::CG_K)
        else $error("J not followed by K");
    esd_pair_a: assert property (
        $rose(mii_clk_o) && tx_cg_o == fe_pcs_pkg::CG_T |-> ##8 tx_cg_o == fe_pcs_pkg::CG_R)
        else $error("T not followed by R");
    // Receive flags; the abort error lasts one tick
    abort_pulse_a: assert property (
        $rose(rx_er_o) && !crs_o |-> rx_er_o [*8] ##1 !rx_er_o) else $error("abort error length");
    valid_carrier_a: assert property (
        rx_dv_o |-> crs_o) else $error("valid without carrier");
    bad_sym_a: assert property (
        rx_er_o && crs_o |-> rxd_o == fe_pcs_pkg::NIB_ERROR) else $error("error nibble wrong");
    // Link events
    no_link10_a: assert property (
        !link10_o) else $error("slow link raised");
    loss_event_a: assert property (
        link_lost_o |-> $past(link_up_o) && !link_up_o) else $error("loss without link drop");
    restart_a: assert property (
        link_lost_o |-> an_restart_o == an_enable_i) else $error("restart wrong");
    cover property ($rose(mii_clk_o) && tx_cg_o == fe_pcs_pkg::CG_J);
    cover property ($rose(rx_er_o) && !crs_o);
    cover property (rx_er_o && crs_o);
    cover property (tx_flp_o);
endmodule // fe_pcs_chk
bind fe_pcs_pma fe_pcs_chk u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .mii_clk_o(mii_clk_o), .tx_en_i(tx_en_i), .tx_cg_o(tx_cg_o),
    .tx_flp_o(tx_flp_o), .rxd_o(rxd_o), .rx_dv_o(rx_dv_o), .rx_er_o(rx_er_o), .crs_o(crs_o),
    .an_enable_i(an_enable_i), .link_override_i(link_override_i), .link_up_o(link_up_o),
    .link_lost_o(link_lost_o), .an_restart_o(an_restart_o), .link10_o(link10_o));
`default_nettype wire

//--- dv/mac_model.sv
/*
 MAC model: sends nibble frames over MII transmit.
 Assumes mii_clk_i comes from the PHY and ticks on its rising edge.
*/
`timescale 1ns/1ps
`default_nettype none
module mac_model (
    input wire logic clk_i, // System clock
    input wire logic mii_clk_i, // MII clock from the PHY
    output logic tx_en_o, // Transmit enable
    output logic tx_er_o, // Transmit error
    output logic [3:0] txd_o // Transmit nibble
);
    // ------
    // Frame sender
    // ------
    // Quiet at time zero
    initial begin
        tx_en_o = 1'b0;
        tx_er_o = 1'b0;
        txd_o = 4'hA;
    end
    // Nibble k carries k mod 16; gap timed by its own ticks, never by carrier
    task automatic send(input int len, input int err);
        for (int k = 0; k < len; k++) begin
            @(negedge mii_clk_i);
            @(posedge clk_i);
            tx_en_o <= 1'b1;
            tx_er_o <= (k == err);
            txd_o <= k[3:0];
        end
        @(negedge mii_clk_i);
        @(posedge clk_i);
        tx_en_o <= 1'b0;
        tx_er_o <= 1'b0;
        txd_o <= ~txd_o; // Released lines must not keep the last nibble
    endtask
endmodule // mac_model
`default_nettype wire

//--- dv/tb.sv
/*
 Bench for the coding block: MAC model on transmit, bench tasks on receive.
 Assumes the checker binds itself; link-up needs 50 ms, so it is not reached.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
    // ------
    // Signals, clock, design and tasks
    // ------
    localparam logic [4:0] CG_DATA [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
        5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
    localparam logic [4:0] CG_BAD [10] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h05, 5'h06, 5'h08, 5'h0C, 5'h10, 5'h19};
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [4:0] rx_cg_i = fe_pcs_pkg::CG_IDLE;
    logic lock_i = 1'b0;
    logic link10_hint_i = 1'b0;
    logic an_enable_i = 1'b0;
    logic link_override_i = 1'b0;
    logic tx_en_i;
    logic tx_er_i;
    logic [3:0] txd_i;
    logic mii_clk_o;
    logic [4:0] tx_cg_o;
    logic tx_flp_o;
    logic [3:0] rxd_o;
    logic rx_dv_o;
    logic rx_er_o;
    logic crs_o;
    logic link_up_o;
    logic link10_o;
    int bad_count = 0;
    int num_checks = 0;
    logic [6:0] pend_e = 7'h00;
    logic [6:0] pend_m = 7'h00;
    time t0;
    always #2.5 clk_i = ~clk_i;
    fe_pcs_pma dut (.clk_i(clk_i), .rst_i(rst_i), .mii_clk_o(mii_clk_o), .tx_en_i(tx_en_i), .tx_er_i(tx_er_i),
        .txd_i(txd_i), .tx_cg_o(tx_cg_o), .tx_flp_o(tx_flp_o), .rx_cg_i(rx_cg_i), .lock_i(lock_i),
        .link10_hint_i(link10_hint_i), .rxd_o(rxd_o), .rx_dv_o(rx_dv_o), .rx_er_o(rx_er_o), .crs_o(crs_o),
        .an_enable_i(an_enable_i), .link_override_i(link_override_i), .link_up_o(link_up_o),
        .link_lost_o(), .an_restart_o(), .link10_o(link10_o));
    mac_model mac (.clk_i(clk_i), .mii_clk_i(mii_clk_o), .tx_en_o(tx_en_i), .tx_er_o(tx_er_i), .txd_o(txd_i));
    // Masked compare; an unknown in a checked bit never matches
    task automatic chk(input logic [6:0] got, input logic [6:0] exp, input logic [6:0] m);
        num_checks++;
        if ((got & m) !== (exp & m)) begin
            bad_count++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic done(input string s);
        $display("end of test %s, mismatches %0d", s, bad_count);
    endtask
    // One group per tick; the decoder lags one tick, so each call checks the
    // previous group's result, read mid-tick as {crs, dv, er, rxd}
    task automatic rx_sym(input logic [4:0] cg, input logic [6:0] e, input logic [6:0] m);
        @(posedge clk_i);
        rx_cg_i <= cg;
        @(posedge mii_clk_o);
        @(negedge mii_clk_o);
        chk({crs_o, rx_dv_o, rx_er_o, rxd_o}, pend_e, pend_m);
        pend_e = e;
        pend_m = m;
    endtask
    task automatic tx_quiet();
        fork
            mac.send(6, -1);
            repeat (9) begin
                @(negedge mii_clk_o);
                chk({2'b00, tx_cg_o}, {2'b00, fe_pcs_pkg::CG_IDLE}, 7'h1F);
            end
        join
    endtask
    task automatic tx_frame(input int len, input int err);
        logic [4:0] w;
        int n;
        fork
            mac.send(len, err);
            begin
                for (n = 0; n < 40 && tx_cg_o === fe_pcs_pkg::CG_IDLE; n++)
                    @(negedge mii_clk_o);
                if (n == 40) begin
                    bad_count++;
                    $display("BAD %0t no frame start", $time);
                    conclude();
                end
                for (int i = 0; i < len + 3; i++) begin
                    if (i == 0) w = fe_pcs_pkg::CG_J;
                    else if (i == 1) w = fe_pcs_pkg::CG_K;
                    else if (i == err) w = fe_pcs_pkg::CG_H;
                    else if (i < len) w = CG_DATA[i % 16];
                    else if (i == len) w = fe_pcs_pkg::CG_T;
                    else if (i == len + 1) w = fe_pcs_pkg::CG_R;
                    else w = fe_pcs_pkg::CG_IDLE;
                    chk({2'b00, tx_cg_o}, {2'b00, w}, 7'h1F);
                    @(negedge mii_clk_o);
                end
            end
        join
    endtask
    // Hang guard
    initial begin
        repeat (20000) @(posedge clk_i);
        bad_count++;
        $display("BAD %0t run too long", $time);
        conclude();
    end
    // Main sequence
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge mii_clk_o);
        t0 = $time;
        @(posedge mii_clk_o);
        chk({6'h00, $time - t0 == 40}, 7'h01, 7'h01);
        chk({2'b00, tx_cg_o}, {2'b00, fe_pcs_pkg::CG_IDLE}, 7'h1F);
        done("reset");
        tx_quiet();
        @(posedge clk_i);
        an_enable_i <= 1'b1;
        link_override_i <= 1'b1;
        tx_quiet();
        chk({6'h00, tx_flp_o}, 7'h01, 7'h01);
        @(posedge clk_i);
        an_enable_i <= 1'b0;
        tx_frame(18, -1);
        tx_frame(8, 4);
        chk({6'h00, tx_flp_o}, 7'h00, 7'h01);
        done("transmit");
        @(posedge clk_i);
        link_override_i <= 1'b0;
        rx_sym(fe_pcs_pkg::CG_IDLE, 7'h00, 7'h70);
        rx_sym(fe_pcs_pkg::CG_J, 7'h65, 7'h7F);
        rx_sym(fe_pcs_pkg::CG_K, 7'h65, 7'h7F);
        for (int k = 0; k < 16; k++)
            rx_sym(CG_DATA[k], {3'b110, k[3:0]}, 7'h7F);
        rx_sym(fe_pcs_pkg::CG_T, 7'h40, 7'h60);
        rx_sym(fe_pcs_pkg::CG_R, 7'h00, 7'h70);
        rx_sym(fe_pcs_pkg::CG_J, 7'h65, 7'h7F);
        rx_sym(fe_pcs_pkg::CG_K, 7'h65, 7'h7F);
        rx_sym(CG_DATA[3], 7'h63, 7'h7F);
        rx_sym(fe_pcs_pkg::CG_IDLE, 7'h10, 7'h50);
        rx_sym(fe_pcs_pkg::CG_IDLE, 7'h00, 7'h70);
        rx_sym(fe_pcs_pkg::CG_J, 7'h65, 7'h7F);
        rx_sym(fe_pcs_pkg::CG_K, 7'h65, 7'h7F);
        for (int k = 0; k < 10; k++)
            rx_sym(CG_BAD[k], 7'h15, 7'h1F);
        rx_sym(fe_pcs_pkg::CG_T, 7'h00, 7'h00);
        rx_sym(fe_pcs_pkg::CG_R, 7'h00, 7'h00);
        rx_sym(fe_pcs_pkg::CG_IDLE, 7'h00, 7'h70);
        rx_sym(fe_pcs_pkg::CG_IDLE, 7'h00, 7'h00);
        done("receive");
        @(posedge clk_i);
        lock_i <= 1'b1;
        link10_hint_i <= 1'b1;
        repeat (3000) @(posedge clk_i);
        chk({6'h00, link_up_o}, 7'h00, 7'h01);
        chk({6'h00, link10_o}, 7'h00, 7'h01);
        lock_i <= 1'b0;
        done("link");
        conclude();
    end
endmodule // tb
`default_nettype wire
